// [design/shsr_top.sv]
// Slave select, address strap and host request handshake logic
// Summary of operation
// R1: SPI slave transfers only while select low
// R2: Outside keeps select high in master mode
// R3: Select low in SPI master sets error
// R4: Select high: ignore clocks, release data out
// R5: I2C slave uses strap bit two
// R6: Request pin output as slave, input master
// R7: Slave asserts request, releases on first clock
// R8: Master starts word on each fresh request
// R9: Request released in reset or mode off
// R10: I2C slave uses strap bit zero
// R11: Select and request inputs synchronised first
`timescale 1ns/1ps
module shsr_top
  import shsr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       soft_rst,
  input  wire logic       is_master,
  input  wire logic       is_i2c,
  input  wire logic [1:0] request_pin_mode_field,
  input  wire logic       slave_select_n,
  input  wire logic       sck_in,
  input  wire logic       miso_data,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit2,
  input  wire logic       host_request_n_in,
  input  wire logic       word_ready,
  input  wire logic       word_done,
  input  wire logic       bus_error_clr,
  output logic            host_request_n_out,
  output logic            host_request_n_oe,
  output logic            miso_out,
  output logic            miso_oe,
  output logic            sck_edge,
  output logic            master_start,
  output logic            bus_error,
  output logic [6:0]      slave_addr
);
  logic ss_s;
  logic sck_s;
  logic req_in_s;
  logic a0_s;
  logic a2_s;

  // Every outside pin passes the three-stage synchroniser
  shsr_sync u_ss  (.core_clk(core_clk), .rst(rst), .pin_in(slave_select_n),
                   .level_out(ss_s)); // [R11]
  shsr_sync u_sck (.core_clk(core_clk), .rst(rst), .pin_in(sck_in), .level_out(sck_s));
  shsr_sync u_req (.core_clk(core_clk), .rst(rst), .pin_in(host_request_n_in),
                   .level_out(req_in_s)); // [R11]
  shsr_sync u_a0  (.core_clk(core_clk), .rst(rst), .pin_in(addr_strap_bit0),
                   .level_out(a0_s));
  shsr_sync u_a2  (.core_clk(core_clk), .rst(rst), .pin_in(addr_strap_bit2),
                   .level_out(a2_s));

  logic        spi_slave;
  logic        spi_master;
  logic        i2c_slave;
  logic        req_off;
  logic        rise;
  logic        sel_rise;
  logic        sck_d_r;
  logic        sck_d_nxt;
  logic        armed_r;
  logic        armed_nxt;
  shsr_state_e st_r;
  shsr_state_e st_nxt;
  logic        req_o_r;
  logic        req_o_nxt;
  logic        req_oe_r;
  logic        req_oe_nxt;
  logic        miso_r;
  logic        miso_nxt;
  logic        miso_oe_r;
  logic        miso_oe_nxt;
  logic        edge_r;
  logic        edge_nxt;
  logic        start_r;
  logic        start_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [6:0]  addr_r;
  logic [6:0]  addr_nxt;

  assign spi_slave  = !is_i2c && !is_master;
  assign spi_master = !is_i2c && is_master;
  assign i2c_slave  = is_i2c && !is_master;
  assign req_off    = soft_rst || (request_pin_mode_field == REQ_MODE_OFF);
  assign rise       = sck_s && !sck_d_r;
  // SPI clocks count only while selected; I2C has no select
  assign sel_rise   = rise && (is_i2c || !ss_s);

  always_comb begin
    sck_d_nxt   = sck_s;
    edge_nxt    = 1'b0;
    start_nxt   = 1'b0;
    st_nxt      = st_r;
    armed_nxt   = armed_r;
    req_o_nxt   = PIN_HIGH;
    req_oe_nxt  = OE_OFF;
    miso_nxt    = PIN_HIGH;
    miso_oe_nxt = OE_OFF;
    // A new error wins over a clear in the same cycle
    err_nxt     = err_r && !bus_error_clr;
    addr_nxt    = addr_r;
    if (spi_master && !ss_s) begin
      err_nxt = 1'b1; // [R3]
    end
    if (spi_slave && !ss_s) begin
      miso_nxt    = miso_data; // [R1]
      miso_oe_nxt = OE_ON;
      edge_nxt    = rise;
    end // Otherwise data out released and clocks ignored [R4]
    if (i2c_slave) begin
      addr_nxt                = I2C_ADDR_BASE;
      addr_nxt[ADDR_BIT0_POS] = a0_s; // [R10]
      addr_nxt[ADDR_BIT2_POS] = a2_s; // [R5]
    end
    if (req_off) begin
      st_nxt    = SHSR_IDLE; // [R9]
      armed_nxt = 1'b1;
    end else if (!is_master) begin
      req_oe_nxt = OE_ON; // [R6]
      case (st_r)
        SHSR_IDLE: begin
          if (word_ready) begin
            st_nxt = SHSR_WAIT;
          end
        end
        SHSR_WAIT: begin
          req_o_nxt = 1'b0; // [R7]
          if (sel_rise) begin
            req_o_nxt = PIN_HIGH; // [R7]
            st_nxt    = SHSR_BUSY;
          end
        end
        SHSR_BUSY: begin
          if (word_done) begin
            st_nxt = SHSR_IDLE;
          end
        end
        default: begin
          st_nxt = SHSR_IDLE;
        end
      endcase
    end else begin
      // Pin is an input here; a start needs it seen high since the last one [R6]
      if (req_in_s) begin
        armed_nxt = 1'b1;
      end
      case (st_r)
        SHSR_IDLE: begin
          if (!req_in_s && armed_r) begin
            start_nxt = 1'b1; // [R8]
            armed_nxt = 1'b0;
            st_nxt    = SHSR_BUSY;
          end
        end
        SHSR_BUSY: begin
          if (word_done) begin
            st_nxt = SHSR_IDLE;
          end
        end
        default: begin
          st_nxt = SHSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Same level as the synchroniser preset, so no false edge after reset
      sck_d_r   <= PIN_HIGH;
      armed_r   <= 1'b1;
      st_r      <= SHSR_IDLE;
      req_o_r   <= PIN_HIGH;
      req_oe_r  <= OE_OFF; // [R9]
      miso_r    <= PIN_HIGH;
      miso_oe_r <= OE_OFF;
      edge_r    <= 1'b0;
      start_r   <= 1'b0;
      err_r     <= 1'b0;
      addr_r    <= I2C_ADDR_BASE;
    end else begin
      sck_d_r   <= sck_d_nxt;
      armed_r   <= armed_nxt;
      st_r      <= st_nxt;
      req_o_r   <= req_o_nxt;
      req_oe_r  <= req_oe_nxt;
      miso_r    <= miso_nxt;
      miso_oe_r <= miso_oe_nxt;
      edge_r    <= edge_nxt;
      start_r   <= start_nxt;
      err_r     <= err_nxt;
      addr_r    <= addr_nxt;
    end
  end

  assign host_request_n_out = req_o_r;
  assign host_request_n_oe  = req_oe_r;
  assign miso_out           = miso_r;
  assign miso_oe            = miso_oe_r;
  assign sck_edge           = edge_r;
  assign master_start       = start_r;
  assign bus_error          = err_r;
  assign slave_addr         = addr_r;

  sequence s_wait_rise;
    st_r == SHSR_WAIT && sel_rise && !req_off && !is_master;
  endsequence
  sequence s_wait_still;
    st_r == SHSR_WAIT && !rise && !req_off && !is_master;
  endsequence

  a_err_sets: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    spi_master && !ss_s |=> err_r)
    else $error("bus error not set");
  a_err_sticky: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    err_r && !bus_error_clr |=> err_r)
    else $error("bus error lost");
  a_miso_hiz: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    ss_s |=> miso_oe_r == OE_OFF && !edge_r)
    else $error("miso driven");
  a_sel_only: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    miso_oe_r == OE_ON |-> $past(spi_slave && !ss_s))
    else $error("bad enable");
  a_edge_sel: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    edge_r |-> $past(spi_slave && !ss_s && rise))
    else $error("clock edge while not selected");
  a_req_off: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    req_off |=> req_oe_r == OE_OFF)
    else $error("request pin driven");
  a_req_master: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    is_master |=> req_oe_r == OE_OFF)
    else $error("request driven as master");
  a_req_release: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    s_wait_rise |=> req_o_r)
    else $error("request not released");
  a_req_assert: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    s_wait_still |=> !req_o_r)
    else $error("request not asserted");
  a_fresh_req: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    master_start |-> !$past(req_in_s) && !$past(master_start))
    else $error("start without request");
  a_start_mode: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    master_start |-> $past(is_master && !req_off))
    else $error("start outside master mode");
  a_addr_bits: assert property (@(posedge core_clk) disable iff (rst) // [R5] [R10]
    i2c_slave |=> slave_addr[0] == $past(a0_s) && slave_addr[2] == $past(a2_s))
    else $error("strap bits wrong");
  a_addr_hold: assert property (@(posedge core_clk) disable iff (rst) // [R5] [R10]
    !i2c_slave |=> slave_addr == $past(slave_addr))
    else $error("address moved outside slave mode");
endmodule

// [design/shsr_pkg.sv]
// Package of constants for the serial host select/request block
package shsr_pkg;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [1:0] REQ_MODE_OFF = 2'h0;
  localparam logic [6:0] I2C_ADDR_BASE = 7'h2a;
  localparam int unsigned ADDR_BIT0_POS = 0;
  localparam int unsigned ADDR_BIT2_POS = 2;
  localparam logic PIN_HIGH = 1'h1;
  localparam logic OE_OFF = 1'h1;
  localparam logic OE_ON = 1'h0;
  typedef enum logic [1:0] {
    SHSR_IDLE = 2'h0,
    SHSR_WAIT = 2'h1,
    SHSR_BUSY = 2'h3
  } shsr_state_e;
endpackage

// [design/shsr_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module shsr_sync
  import shsr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stg_r;
  logic [2:0] stg_nxt;
  logic       lvl_r;
  logic       lvl_nxt;

  always_comb begin
    stg_nxt = {stg_r[1:0], pin_in};
    lvl_nxt = (stg_r[1] == stg_r[2]) ? stg_r[2] : lvl_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stg_r <= 3'h7;
      lvl_r <= PIN_HIGH;
    end else begin
      stg_r <= stg_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule

// [sim/shsr_far_model.sv]
// Far-side model: select, serial clock and request lines of the host or slave
`timescale 1ns/1ps
module shsr_far_model (
  output logic slave_select_n,
  output logic sck_in,
  output logic req_n
);
  initial begin
    slave_select_n = 1'b1;
    sck_in = 1'b0;
    req_n = 1'b1;
  end
  // Clock only inside frames; sel high selects this port, low means another slave
  task automatic frame(input logic sel, input int pulses);
    slave_select_n = !sel;
    #400;
    repeat (pulses) begin
      #160 sck_in = 1'b1;
      #160 sck_in = 1'b0;
    end
    #400 slave_select_n = 1'b1;
  endtask
  task automatic request(input logic lvl);
    req_n = lvl;
  endtask
endmodule

// [sim/tb_shsr_top.sv]
// Self-checking bench for the select, strap and request block
`timescale 1ns/1ps
module tb_shsr_top
  import shsr_pkg::*;
;
  logic       core_clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, is_master = 1'b0;
  logic       is_i2c = 1'b0, miso_data = 1'b0, addr_strap_bit0 = 1'b0, addr_strap_bit2 = 1'b0;
  logic       word_ready = 1'b0, word_done = 1'b0, bus_error_clr = 1'b0;
  logic [1:0] request_pin_mode_field = 2'h1;
  logic       slave_select_n, sck_in, far_req_n, host_request_n_in;
  logic       host_request_n_out, host_request_n_oe, miso_out, miso_oe;
  logic       sck_edge, master_start, bus_error;
  logic [6:0] slave_addr;
  int         errors = 0, n_checks = 0, n_edge = 0, n_start = 0;

  always #20 core_clk = ~core_clk;
  // Request wire: device when enabled, else the far side
  assign host_request_n_in = (host_request_n_oe === OE_ON) ? host_request_n_out : far_req_n;

  shsr_top shsr_top_i (.core_clk, .rst, .soft_rst, .is_master, .is_i2c, .request_pin_mode_field,
    .slave_select_n, .sck_in, .miso_data, .addr_strap_bit0, .addr_strap_bit2, .host_request_n_in,
    .word_ready, .word_done, .bus_error_clr, .host_request_n_out, .host_request_n_oe, .miso_out,
    .miso_oe, .sck_edge, .master_start, .bus_error, .slave_addr);
  shsr_far_model shsr_far_model_i (.slave_select_n, .sck_in, .req_n(far_req_n));

  always @(posedge core_clk) begin
    if (sck_edge === 1'b1) n_edge++;
    if (master_start === 1'b1) n_start++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wq(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic slave_arm;
    word_done = 1'b1;
    wq(1);
    word_done = 1'b0;
    word_ready = 1'b1;
    wq(1);
    word_ready = 1'b0;
    wq(8);
  endtask

  task automatic t_slave;
    slave_arm();
    chk(8'({host_request_n_oe, host_request_n_out}), 8'h0);
    n_edge = 0;
    fork
      shsr_far_model_i.frame(1'b1, 4);
      begin
        wq(30);
        chk(8'({miso_oe, miso_out}), 8'({OE_ON, miso_data}));
      end
    join
    wq(8);
    chk(8'(host_request_n_out), 8'h1);
    chk(8'(n_edge), 8'h4);
    word_done = 1'b1;
    wq(1);
    word_done = 1'b0;
    n_edge = 0;
    shsr_far_model_i.frame(1'b0, 4);
    wq(8);
    chk(8'(n_edge), 8'h0);
    chk(8'(miso_oe), 8'h1);
    $display("slave test done");
  endtask
  task automatic t_master;
    is_master = 1'b1;
    wq(8);
    chk(8'(host_request_n_oe), 8'h1);
    n_start = 0;
    shsr_far_model_i.request(1'b0);
    wq(20);
    chk(8'(n_start), 8'h1);
    word_done = 1'b1;
    wq(1);
    word_done = 1'b0;
    shsr_far_model_i.request(1'b1);
    wq(8);
    shsr_far_model_i.request(1'b0);
    wq(10);
    chk(8'(n_start), 8'h2);
    shsr_far_model_i.request(1'b1);
    shsr_far_model_i.frame(1'b1, 0);
    wq(8);
    chk(8'(bus_error), 8'h1);
    bus_error_clr = 1'b1;
    wq(1);
    bus_error_clr = 1'b0;
    wq(2);
    chk(8'(bus_error), 8'h0);
    $display("master test done");
  endtask
  task automatic t_i2c;
    is_master = 1'b0;
    is_i2c = 1'b1;
    slave_arm();
    chk(8'(host_request_n_out), 8'h0);
    shsr_far_model_i.frame(1'b0, 1);
    wq(8);
    chk(8'(host_request_n_out), 8'h1);
    for (int k = 0; k < 4; k++) begin
      {addr_strap_bit2, addr_strap_bit0} = k[1:0];
      wq(8);
      chk(8'(slave_addr), 8'h2a | 8'({k[1], 1'b0, k[0]}));
    end
    is_master = 1'b1;
    wq(8);
    {addr_strap_bit2, addr_strap_bit0} = 2'h0;
    wq(8);
    chk(8'(slave_addr), 8'h2f);
    $display("address test done");
  endtask
  task automatic t_off;
    is_master = 1'b0;
    is_i2c = 1'b0;
    slave_arm();
    chk(8'(host_request_n_out), 8'h0);
    request_pin_mode_field = REQ_MODE_OFF;
    wq(2);
    chk(8'(host_request_n_oe), 8'h1);
    request_pin_mode_field = 2'h1;
    soft_rst = 1'b1;
    wq(2);
    chk(8'(host_request_n_oe), 8'h1);
    soft_rst = 1'b0;
    $display("release test done");
  endtask

  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    wq(5);
    chk(8'({host_request_n_oe, miso_oe, bus_error}), 8'h6);
    chk(8'(slave_addr), 8'h2a);
    wq(1);
    rst = 1'b0;
    wq(4);
    t_slave();
    t_master();
    t_i2c();
    t_off();
    summarize();
  end
endmodule
